// [lcdsd_pkg.sv]
// Constants, field positions and carrier types for the segment LCD control block.
// Assumes a 32-bit AHB-Lite bus and 8-bit registers placed at word index times four.
package lcdsd_pkg;
   // Register word indices; byte address is index * 4
   localparam logic [29:0] PIN_FUNC_IDX = 30'h0000ffc0;
   localparam logic [29:0] POWER_SHOW_DISPLAY_RAM_IDX = 30'h0000ffc1;
   localparam logic [29:0] WAVEFORM_IDX = 30'h0000ffc2;

   // Reset values
   localparam logic [7:0] PIN_FUNC_RST = 8'h00;
   localparam logic [7:0] POWER_SHOW_DISPLAY_RAM_RST = 8'h80;
   localparam logic [7:0] WAVEFORM_RST = 8'h60;

   // Pin function control fields
   localparam int DUTY_SEL_HI_BIT = 7;
   localparam int DUTY_SEL_LO_BIT = 6;
   localparam int COMMON_MIRROR_BIT = 5;
   localparam int SEGMENT_EXTENSION_BIT = 4;
   localparam int SEGMENT_SELECT_3_BIT = 3;

   // Power and display control fields
   localparam int DRIVE_POWER_ON_BIT = 6;
   localparam int CONTROLLER_ACTIVATE_BIT = 5;
   localparam int SHOW_DISPLAY_RAM_BIT = 4;
   localparam int FRAME_CLOCK_SELECT_3_BIT = 3;

   // Waveform control field
   localparam int WAVEFORM_TYPE_B_BIT = 7;

   // Segment driver masks, pin n is bit n-1
   localparam logic [31:0] SEG_MASK_NONE = 32'h00000000;
   localparam logic [31:0] SEG_MASK_TOP8 = 32'hff000000;
   localparam logic [31:0] SEG_MASK_TOP16 = 32'hffff0000;
   localparam logic [31:0] SEG_MASK_TOP24 = 32'hffffff00;
   localparam logic [31:0] SEG_MASK_ALL = 32'hffffffff;

   typedef enum logic [1:0] {
      DUTY_STATIC = 2'b00,
      DUTY_HALF = 2'b01,
      DUTY_THIRD = 2'b10,
      DUTY_QUARTER = 2'b11
   } lcdsd_duty_t;

   // Drive pattern handed to the analog pin stage
   typedef struct packed {
      logic [3:0] com_on;
      logic com_invert;
      logic [31:0] seg_on;
      logic [31:0] seg_is_driver;
   } lcdsd_drive_t;
endpackage

// [lcdsd_ctrl.sv]
// Segment LCD controller: AHB-Lite register file, frame clock selection, common
// sequencing and segment pin assignment. Assumes lcd_ram_i is stable display RAM
// (row per common, 32 bits each) and sub_clk_i is an asynchronous slow clock.
//
// How it works
// R1: Duty field bits 7:6 pick static, half, third or quarter duty.
// R2: Duty code 00 runs a single common phase.
// R3: Mirror bit set copies a used common's waveform onto unused commons.
// R4: Mirror bit clear leaves unused commons idle.
// R5: Extension clear, select bits 3:1 zero: all segment pins are ports.
// R6: Select 001x: pins 32..25 drive, rest ports.
// R7: Select 010x: pins 32..17 drive, rest ports.
// R8: Select 011x: pins 32..9 drive, rest ports.
// R9: Select bit 3 set: all thirty-two pins drive.
// R10: Drive power bit 6 turns the LCD supply on or off.
// R11: Software may clear drive power when display unused or supply external.
// R12: Activate clear or standby forces the supply off.
// R13: Activate bit 5 clear halts the controller, set lets it run.
// R14: Halting keeps every control register value.
// R15: Four-bit frame clock select picks the frame clock source.
// R16: Waveform bit selects A or B drive waveform.
// R17: Top bit 0 picks sub-clock /1,/2,/4; top bit 1 picks system /2../256.
// R18: Waveform bit 7 of the waveform register: 0 A, 1 B.
// R19: Display bit 4 shows RAM when 1, blank when 0.
// R20: Non-driver segment pins carry no LCD waveform.
// R21: Control registers read back the last written values.
`timescale 1ns/100ps
module lcdsd_ctrl (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Chip side
   input wire logic standby_i,
   input wire logic sub_clk_i,
   input wire logic [127:0] lcd_ram_i,
   // Panel side
   output lcdsd_pkg::lcdsd_drive_t drive_o,
   output logic drive_power_o
);
   import lcdsd_pkg::*;

   // Bus and register state
   logic [7:0] pin_func_reg, pin_func_next;
   logic [7:0] power_show_display_ram_reg, power_show_display_ram_next;
   logic [7:0] waveform_reg, waveform_next;
   logic wr_pend_reg, wr_pend_next;
   logic [29:0] wr_idx_reg, wr_idx_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic addr_phase;
   logic [29:0] rd_idx;
   logic [7:0] rd_val;

   assign addr_phase = hsel_i & htrans_i[1] & hready_i;
   assign rd_idx = haddr_i[31:2];

   always_comb begin
      pin_func_next = pin_func_reg; // R14
      power_show_display_ram_next = power_show_display_ram_reg;
      waveform_next = waveform_reg;
      wr_pend_next = addr_phase & hwrite_i;
      wr_idx_next = addr_phase ? rd_idx : wr_idx_reg;
      hrdata_next = hrdata_reg;
      rd_val = 8'h00;
      // Data phase write lands here; only hwdata[7:0] is stored
      if (wr_pend_reg) begin
         case (wr_idx_reg)
            PIN_FUNC_IDX: pin_func_next = hwdata_i[7:0]; // R21
            POWER_SHOW_DISPLAY_RAM_IDX: power_show_display_ram_next = hwdata_i[7:0]; // R21
            WAVEFORM_IDX: waveform_next = hwdata_i[7:0]; // R21
            default: ;
         endcase
      end
      // Read forwards a write finishing in the same cycle
      case (rd_idx)
         PIN_FUNC_IDX: rd_val = pin_func_next;
         POWER_SHOW_DISPLAY_RAM_IDX: rd_val = power_show_display_ram_next;
         WAVEFORM_IDX: rd_val = waveform_next;
         default: rd_val = 8'h00;
      endcase
      if (addr_phase && !hwrite_i) begin
         hrdata_next = {24'h000000, rd_val};
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_func_reg <= PIN_FUNC_RST;
         power_show_display_ram_reg <= POWER_SHOW_DISPLAY_RAM_RST;
         waveform_reg <= WAVEFORM_RST;
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 30'h00000000;
         hrdata_reg <= 32'h00000000;
      end else if (ce_i) begin
         pin_func_reg <= pin_func_next;
         power_show_display_ram_reg <= power_show_display_ram_next;
         waveform_reg <= waveform_next;
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg <= wr_idx_next;
         hrdata_reg <= hrdata_next;
      end
   end

   // Zero-wait slave, always OKAY
   logic hreadyout_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hreadyout_reg <= 1'b0;
      end else begin
         hreadyout_reg <= 1'b1;
      end
   end
   assign hreadyout_o = hreadyout_reg;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_reg;

   // Field decode
   lcdsd_duty_t duty;
   logic mirror, seg_ext, act, drive_power_on, show, wave_b;
   logic [3:0] seg_sel, cks;
   assign duty = lcdsd_duty_t'(pin_func_reg[DUTY_SEL_HI_BIT:DUTY_SEL_LO_BIT]); // R1
   assign mirror = pin_func_reg[COMMON_MIRROR_BIT];
   assign seg_ext = pin_func_reg[SEGMENT_EXTENSION_BIT];
   assign seg_sel = pin_func_reg[SEGMENT_SELECT_3_BIT:0];
   assign drive_power_on = power_show_display_ram_reg[DRIVE_POWER_ON_BIT];
   assign act = power_show_display_ram_reg[CONTROLLER_ACTIVATE_BIT];
   assign show = power_show_display_ram_reg[SHOW_DISPLAY_RAM_BIT];
   assign cks = power_show_display_ram_reg[FRAME_CLOCK_SELECT_3_BIT:0];
   assign wave_b = waveform_reg[WAVEFORM_TYPE_B_BIT];

   // Sub-clock synchroniser; level accepted only when stages two and three agree
   logic sub_s1_reg, sub_s2_reg, sub_s3_reg, sub_lvl_reg, sub_lvl_next;
   logic sub_rise;
   always_comb begin
      sub_lvl_next = (sub_s2_reg == sub_s3_reg) ? sub_s3_reg : sub_lvl_reg;
   end
   assign sub_rise = sub_s2_reg & sub_s3_reg & ~sub_lvl_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sub_s1_reg <= 1'b0;
         sub_s2_reg <= 1'b0;
         sub_s3_reg <= 1'b0;
         sub_lvl_reg <= 1'b0;
      end else if (ce_i) begin
         sub_s1_reg <= sub_clk_i;
         sub_s2_reg <= sub_s1_reg;
         sub_s3_reg <= sub_s2_reg;
         sub_lvl_reg <= sub_lvl_next;
      end
   end

   // Frame timing; counters park at zero while halted
   logic [7:0] pre_reg, pre_next;
   logic [1:0] sub_cnt_reg, sub_cnt_next;
   logic [1:0] slot_reg, slot_next;
   logic half_reg, half_next, frame_reg, frame_next;
   logic frame_tick;
   logic [1:0] last_slot;
   logic [7:0] div_mask;

   always_comb begin
      div_mask = 8'h00;
      frame_tick = 1'b0;
      // System clock /2^(n+1) ticks when the low n+1 prescaler bits are all ones
      div_mask = 8'hff >> (3'h7 - cks[2:0]);
      if (cks[FRAME_CLOCK_SELECT_3_BIT]) begin
         frame_tick = ((pre_reg & div_mask) == div_mask); // R15 R17
      end else begin
         case (cks[1:0])
            2'b00: frame_tick = sub_rise; // R17
            2'b01: frame_tick = sub_rise & sub_cnt_reg[0]; // R17
            default: frame_tick = sub_rise & (&sub_cnt_reg); // R17
         endcase
      end
   end

   assign last_slot = duty; // R1 R2

   always_comb begin
      pre_next = 8'(pre_reg + 8'h01);
      sub_cnt_next = sub_rise ? 2'(sub_cnt_reg + 2'b01) : sub_cnt_reg;
      slot_next = slot_reg;
      half_next = half_reg;
      frame_next = frame_reg;
      if (!act) begin
         pre_next = 8'h00; // R13
         sub_cnt_next = 2'b00;
         slot_next = 2'b00;
         half_next = 1'b0;
         frame_next = 1'b0;
      end else if (frame_tick) begin
         half_next = ~half_reg;
         if (half_reg) begin
            if (slot_reg >= last_slot) begin
               slot_next = 2'b00;
               frame_next = ~frame_reg;
            end else begin
               slot_next = 2'(slot_reg + 2'b01);
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre_reg <= 8'h00;
         sub_cnt_reg <= 2'b00;
         slot_reg <= 2'b00;
         half_reg <= 1'b0;
         frame_reg <= 1'b0;
      end else if (ce_i) begin
         pre_reg <= pre_next;
         sub_cnt_reg <= sub_cnt_next;
         slot_reg <= slot_next;
         half_reg <= half_next;
         frame_reg <= frame_next;
      end
   end

   // Pin pattern
   lcdsd_drive_t drive_reg, drive_next;
   logic drive_power_reg, drive_power_next;
   logic [31:0] seg_mask;
   logic [3:0] com_used;
   logic [1:0] cur_slot;

   // A slot left beyond a shortened duty reads as slot zero until it wraps
   assign cur_slot = (slot_reg > last_slot) ? 2'b00 : slot_reg; // R2

   always_comb begin
      seg_mask = SEG_MASK_NONE; // R5
      if (!seg_ext) begin
         if (seg_sel[3]) begin
            seg_mask = SEG_MASK_ALL; // R9
         end else begin
            case (seg_sel[2:1])
               2'b01: seg_mask = SEG_MASK_TOP8; // R6
               2'b10: seg_mask = SEG_MASK_TOP16; // R7
               2'b11: seg_mask = SEG_MASK_TOP24; // R8
               default: seg_mask = SEG_MASK_NONE; // R5
            endcase
         end
      end
   end

   always_comb begin
      com_used = 4'b0001 << cur_slot;
      drive_next = '0;
      drive_next.seg_is_driver = seg_mask;
      drive_next.com_on = com_used; // R1
      // Unused commons echo the common sharing their slot modulo duty
      case (duty)
         DUTY_STATIC: drive_next.com_on = mirror ? {4{com_used[0]}} : {3'b000, com_used[0]}; // R2 R3 R4
         DUTY_HALF: drive_next.com_on = mirror ? {2{com_used[1:0]}} : {2'b00, com_used[1:0]}; // R3 R4
         DUTY_THIRD: drive_next.com_on = {mirror & com_used[0], com_used[2:0]}; // R3 R4
         default: drive_next.com_on = com_used;
      endcase
      // A inverts every half slot, B once per frame
      drive_next.com_invert = wave_b ? frame_reg : half_reg; // R16 R18
      if (show) begin
         drive_next.seg_on = lcd_ram_i[32 * cur_slot +: 32] & seg_mask; // R19 R20
      end
      if (!act) begin
         drive_next.com_on = 4'h0; // R13
         drive_next.com_invert = 1'b0;
         drive_next.seg_on = 32'h00000000;
      end
      drive_power_next = drive_power_on & act & ~standby_i; // R10 R11 R12
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         drive_reg <= '0;
         drive_power_reg <= 1'b0;
      end else if (ce_i) begin
         drive_reg <= drive_next;
         drive_power_reg <= drive_power_next;
      end
   end
   assign drive_o = drive_reg;
   assign drive_power_o = drive_power_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_write_pin;
      ce_i && wr_pend_reg && wr_idx_reg == PIN_FUNC_IDX;
   endsequence
   sequence s_read_pin;
      ce_i && addr_phase && !hwrite_i && rd_idx == PIN_FUNC_IDX;
   endsequence

   a_pin_readback: assert property (s_write_pin ##1 s_read_pin |=> hrdata_o[7:0] == $past(pin_func_reg)) // R21
      else $error("pin function readback mismatch");
   a_all_ports: assert property (ce_i && !seg_ext && seg_sel[3:1] == 3'b000 |=> drive_o.seg_is_driver == 32'h0) // R5
      else $error("ports expected on all segment pins");
   a_top8_driver: assert property (ce_i && !seg_ext && seg_sel[3:1] == 3'b001 |=> drive_o.seg_is_driver == 32'hff000000) // R6
      else $error("top eight segment pins not drivers");
   a_top16_driver: assert property (ce_i && !seg_ext && seg_sel[3:1] == 3'b010 |=> drive_o.seg_is_driver == 32'hffff0000) // R7
      else $error("top sixteen segment pins not drivers");
   a_top24_driver: assert property (ce_i && !seg_ext && seg_sel[3:1] == 3'b011 |=> drive_o.seg_is_driver == 32'hffffff00) // R8
      else $error("top twenty-four segment pins not drivers");
   a_all_driver: assert property (ce_i && !seg_ext && seg_sel[3] |=> &drive_o.seg_is_driver) // R9
      else $error("all segment pins should drive");
   a_power_forced_off: assert property (ce_i && (!act || standby_i) |=> !drive_power_o) // R12
      else $error("drive supply not forced off");
   a_power_follows_bit: assert property (ce_i && act && !standby_i |=> drive_power_o == $past(drive_power_on)) // R10
      else $error("drive supply does not follow power bit");
   a_halt_quiet: assert property (ce_i && !act |=> drive_o.com_on == 4'h0 && drive_o.seg_on == 32'h0) // R13
      else $error("halted controller still drives");
   a_halt_keeps_regs: assert property (ce_i && !act && !wr_pend_reg |=> $stable(pin_func_reg) && $stable(waveform_reg)) // R14
      else $error("register changed while halted");
   a_static_single: assert property (ce_i && act && duty == DUTY_STATIC && !mirror |=> drive_o.com_on == 4'b0001) // R2 R4
      else $error("static drive must use one common only");
   a_mirror_half: assert property (ce_i && act && duty == DUTY_HALF && mirror |=>
      drive_o.com_on[3:2] == drive_o.com_on[1:0] && $onehot(drive_o.com_on[1:0])) // R3
      else $error("half duty mirror mismatch");
   a_blank_display: assert property (ce_i && !show |=> drive_o.seg_on == 32'h0) // R19
      else $error("blank display shows data");
   a_port_no_wave: assert property (ce_i |=> (drive_o.seg_on & ~drive_o.seg_is_driver) == 32'h0) // R20
      else $error("port pin carries segment data");
   a_sys_div2: assert property (ce_i && cks == 4'h8 && frame_tick ##1 ce_i && cks == 4'h8 |-> !frame_tick) // R17
      else $error("system clock /2 ticks too often");
   a_wave_a_toggle: assert property (ce_i && act && !wave_b && frame_tick ##1 ce_i && act && !wave_b |=>
      drive_o.com_invert != $past(drive_o.com_invert)) // R16 R18
      else $error("A waveform did not invert on frame tick");
endmodule

// [lcdsd_panel.sv]
// Panel model: records which commons and segments were driven.
// Assumes drive_i comes straight from the controller's registered outputs.
`timescale 1ns/100ps
module lcdsd_panel (
   // Clock and clear
   input wire logic clk_i,
   input wire logic clr_i,
   // Drive from controller
   input wire lcdsd_pkg::lcdsd_drive_t drive_i,
   // Observations
   output logic [3:0] com_seen_o,
   output logic [31:0] seg_seen_o,
   output logic port_lit_o
);
   import lcdsd_pkg::*;
   always @(posedge clk_i) begin
      if (clr_i) begin
         com_seen_o <= 4'h0;
         seg_seen_o <= 32'h0;
         port_lit_o <= 1'b0;
      end else begin
         com_seen_o <= com_seen_o | drive_i.com_on;
         seg_seen_o <= seg_seen_o | drive_i.seg_on;
         // Port pins must never see a lit segment
         port_lit_o <= port_lit_o | (|(drive_i.seg_on & ~drive_i.seg_is_driver));
      end
   end
endmodule

// [tb.sv]
// Self-checking bench for the segment LCD controller.
// Assumes one AHB-Lite master (this bench) and the panel model as sink.
`timescale 1ns/100ps
module tb;
   import lcdsd_pkg::*;
   logic clk_i;
   logic rstn_i;
   logic hsel, hwrite, hready, hresp, standby, sub_clk, clr, lit, drive_power;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, seg_seen;
   logic [127:0] ram;
   logic [3:0] com_seen;
   logic [15:0] seed;
   logic [7:0] pv;
   lcdsd_drive_t drive;
   int n_errors, n_tests, cyc, sc, n;
   int codes[6] = '{0, 5, 6, 8, 9, 15};
   int gaps[6] = '{32, 64, 128, 4, 8, 512};

   lcdsd_ctrl u_lcdsd_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .standby_i(standby), .sub_clk_i(sub_clk),
      .lcd_ram_i(ram), .drive_o(drive), .drive_power_o(drive_power));
   lcdsd_panel u_lcdsd_panel (.clk_i(clk_i), .clr_i(clr), .drive_i(drive), .com_seen_o(com_seen),
      .seg_seen_o(seg_seen), .port_lit_o(lit));

   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function logic [31:0] seg_mask(input logic [7:0] v);
      if (v[4]) return SEG_MASK_NONE;
      if (v[3]) return SEG_MASK_ALL;
      case (v[2:1])
         2'h0: return SEG_MASK_NONE;
         2'h1: return SEG_MASK_TOP8;
         2'h2: return SEG_MASK_TOP16;
         default: return SEG_MASK_TOP24;
      endcase
   endfunction
   function logic [3:0] com_exp(input logic [1:0] d, input logic m);
      if (m) return 4'hf;
      return (4'h2 << d) - 4'h1;
   endfunction

   task give_verdict;
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wt(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // Holds each phase until hready is sampled high
   task ahb(input logic w, input logic [29:0] idx, input logic [7:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do begin @(posedge clk_i); end while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do begin @(posedge clk_i); end while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [29:0] idx, input logic [7:0] v);
      logic [31:0] d;
      ahb(1'b1, idx, v, d);
   endtask
   task rdc(input logic [29:0] idx, input logic [7:0] v);
      logic [31:0] d;
      ahb(1'b0, idx, 8'h0, d);
      chk(d, {24'h0, v});
      chk({31'h0, hresp}, 32'h0);
   endtask
   // Cycles to the next change of the commons, or of the polarity when inv is set
   task gap(input logic inv, output int k);
      logic [3:0] c;
      c = inv ? {3'h0, drive.com_invert} : drive.com_on;
      k = 0;
      do begin @(posedge clk_i); k++; end while ((inv ? {3'h0, drive.com_invert} : drive.com_on) === c && k < 600);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Slow sub-clock, period 16 system cycles; also the run limit
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      sc <= sc + 1;
      if (sc == 7) begin
         sc <= 0;
         sub_clk <= ~sub_clk;
      end
      if (cyc == 20000) begin
         n_errors++;
         give_verdict;
      end
   end

   initial begin
      {rstn_i, hsel, haddr, htrans, hwrite, hwdata, standby, sub_clk} = '0;
      {n_errors, n_tests, cyc, sc} = '0;
      clr = 1'b1;
      ram = '1;
      seed = 16'h28;
      wt(5);
      rstn_i <= 1'b1;
      wt(1);
      clr <= 1'b0;
      rdc(PIN_FUNC_IDX, PIN_FUNC_RST);
      rdc(POWER_SHOW_DISPLAY_RAM_IDX, POWER_SHOW_DISPLAY_RAM_RST);
      rdc(WAVEFORM_IDX, WAVEFORM_RST);
      chk({31'h0, drive_power}, 32'h0);
      wr(30'h0000ffc3, 8'hff);
      rdc(30'h0000ffc3, 8'h00);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wr(WAVEFORM_IDX, seed[7:0]);
         rdc(WAVEFORM_IDX, seed[7:0]);
      end
      wr(POWER_SHOW_DISPLAY_RAM_IDX, 8'hf8);
      for (int v = 0; v < 40; v++) begin
         seed = lfsr(seed);
         ram <= {8{seed}};
         pv = (v < 32) ? 8'(v) : seed[7:0];
         wr(PIN_FUNC_IDX, pv);
         rdc(PIN_FUNC_IDX, pv);
         wt(2);
         chk(drive.seg_is_driver, seg_mask(pv));
      end
      chk({31'h0, lit}, 32'h0);
      for (int k = 0; k < 8; k++) begin
         // Software may drop the supply at will
         wr(POWER_SHOW_DISPLAY_RAM_IDX, {1'b1, k[0], k[1], 5'h18});
         standby <= k[2];
         wt(3);
         chk({31'h0, drive_power}, {31'h0, k[0] & k[1] & ~k[2]});
      end
      standby <= 1'b0;
      ram <= '1;
      for (int k = 0; k < 8; k++) begin
         wr(PIN_FUNC_IDX, {k[1:0], k[2], 5'h08});
         wr(POWER_SHOW_DISPLAY_RAM_IDX, 8'hf8);
         clr <= 1'b1;
         wt(2);
         clr <= 1'b0;
         wt(64);
         chk({28'h0, com_seen}, {28'h0, com_exp(k[1:0], k[2])});
         chk(seg_seen, 32'hffffffff);
      end
      wr(POWER_SHOW_DISPLAY_RAM_IDX, 8'he8);
      wt(2);
      clr <= 1'b1;
      wt(1);
      clr <= 1'b0;
      wt(40);
      chk(seg_seen, 32'h0);
      wr(POWER_SHOW_DISPLAY_RAM_IDX, 8'hd8);
      wt(2);
      clr <= 1'b1;
      wt(1);
      clr <= 1'b0;
      wt(40);
      chk({28'h0, com_seen}, 32'h0);
      rdc(PIN_FUNC_IDX, 8'he8);
      rdc(POWER_SHOW_DISPLAY_RAM_IDX, 8'hd8);
      // Quarter duty: one common change per two frame ticks
      wr(PIN_FUNC_IDX, 8'hc8);
      for (int i = 0; i < 6; i++) begin
         wr(POWER_SHOW_DISPLAY_RAM_IDX, {4'hf, 4'(codes[i])});
         gap(1'b0, n);
         gap(1'b0, n);
         gap(1'b0, n);
         chk(32'(n), 32'(gaps[i]));
      end
      // A flips polarity every frame tick, B once per four-slot frame
      wr(POWER_SHOW_DISPLAY_RAM_IDX, 8'hf8);
      for (int i = 0; i < 2; i++) begin
         wr(WAVEFORM_IDX, {i[0], 7'h60});
         gap(1'b1, n);
         gap(1'b1, n);
         gap(1'b1, n);
         chk(32'(n), i[0] ? 32'h10 : 32'h2);
      end
      give_verdict;
   end
endmodule
